// ===== rtl/ufc_function_ctrl.sv
// Function-settings register of the transceiver with suspend and core reset control.
// Assumes register accesses decoded to write strobes on CLK; STP arrives from a pin.
`timescale 1ns/10ps
module ufc_function_ctrl
    import ufc_pkg::*;
#(
    parameter int CORE_RESET_CYCLES = UFC_CORE_RESET_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Register access port
    input wire logic [5:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT,
    // Interface pins
    input wire logic STP,
    output logic DIR,
    output logic RXCMD_REQ,
    // Pull-down controls from elsewhere in the register set
    input wire logic POSITIVE_LINE_PULL_LOW,
    input wire logic NEGATIVE_LINE_PULL_LOW,
    // Analogue and core controls
    output logic LOW_POWER,
    output logic CORE_RESET,
    output logic HS_XCVR_EN,
    output logic FS_XCVR_EN,
    output logic LS_XCVR_EN,
    output logic FS_PREAMBLE_EN,
    output logic TX_NON_DRIVING,
    output logic TX_RAW_BITS,
    output logic TX_NO_SYNC_EOP,
    output logic FS_PULLUP_EN,
    output logic HS_TERM_EN
);
    ////////////////////////////////////////////////////////////////////////////
    // Register and sequencer state
    logic [7:0] settings_r;
    logic [7:0] settings_nxt;
    ufc_state_t state_r;
    ufc_state_t state_nxt;
    logic [UFC_CNT_W-1:0] cnt_r;
    logic [UFC_CNT_W-1:0] cnt_nxt;
    logic stp_s;
    logic stp_d_r;
    logic stp_d_nxt;
    logic wake;
    logic acc_hit;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    ufc_sync u_stp_sync
    (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(STP),
        .q(stp_s)
    );

    assign acc_hit = (REG_ADDR == UFC_ADDR_WRITE) || (REG_ADDR == UFC_ADDR_SET)
        || (REG_ADDR == UFC_ADDR_CLEAR);
    assign wake = !settings_r[UFC_BIT_LOW_POWER_N] && stp_s && !stp_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register update
    always_comb
    begin
        settings_nxt = settings_r;
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                UFC_ADDR_WRITE: settings_nxt = REG_WDATA;
                UFC_ADDR_SET: settings_nxt = settings_r | REG_WDATA;
                UFC_ADDR_CLEAR: settings_nxt = settings_r & ~REG_WDATA;
                default: settings_nxt = settings_r;
            endcase
        end
        // Hardware updates (wake set, core reset bit set and end-of-run clear) win over a same-cycle software write
        if (wake)
            settings_nxt[UFC_BIT_LOW_POWER_N] = 1'b1;
        if (state_r == UFC_ST_CORE_RST && cnt_r == '0)
            settings_nxt[UFC_BIT_CORE_RESET] = 1'b0;
        else if (state_r == UFC_ST_CORE_RST)
            settings_nxt[UFC_BIT_CORE_RESET] = 1'b1;
        rdata_nxt = acc_hit ? settings_nxt : 8'h00;
        stp_d_nxt = stp_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core reset sequencer
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            UFC_ST_IDLE:
            begin
                if (settings_r[UFC_BIT_CORE_RESET])
                begin
                    state_nxt = UFC_ST_CORE_RST;
                    cnt_nxt = UFC_CNT_W'(CORE_RESET_CYCLES - 1);
                end
            end
            UFC_ST_CORE_RST:
            begin
                if (cnt_r == '0)
                    state_nxt = UFC_ST_RXCMD;
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            UFC_ST_RXCMD:
                state_nxt = UFC_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            settings_r <= UFC_RESET_VAL;
            state_r <= UFC_ST_IDLE;
            cnt_r <= '0;
            stp_d_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else if (CE)
        begin
            settings_r <= settings_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            stp_d_r <= stp_d_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign REG_RDATA = rdata_r;
    assign REG_HIT = acc_hit;
    assign DIR = (state_r == UFC_ST_CORE_RST);
    assign CORE_RESET = (state_r == UFC_ST_CORE_RST);
    assign RXCMD_REQ = (state_r == UFC_ST_RXCMD);
    assign LOW_POWER = !settings_r[UFC_BIT_LOW_POWER_N];

    logic [1:0] style;
    logic [1:0] speed;
    logic host_pd;
    assign style = settings_r[UFC_BIT_STYLE_HI:UFC_BIT_STYLE_LO];
    assign speed = settings_r[UFC_BIT_SPEED_HI:UFC_BIT_SPEED_LO];
    assign host_pd = POSITIVE_LINE_PULL_LOW && NEGATIVE_LINE_PULL_LOW;

    assign TX_NON_DRIVING = (style == UFC_STYLE_NODRIVE);
    assign TX_RAW_BITS = (style == UFC_STYLE_RAW);
    assign TX_NO_SYNC_EOP = (style == UFC_STYLE_NOSYNC);
    assign HS_XCVR_EN = !LOW_POWER && (speed == UFC_SPEED_HS);
    assign FS_XCVR_EN = !LOW_POWER && (speed == UFC_SPEED_FS
        || speed == UFC_SPEED_LS_ON_FS);
    assign LS_XCVR_EN = !LOW_POWER && (speed == UFC_SPEED_LS);
    assign FS_PREAMBLE_EN = !LOW_POWER && (speed == UFC_SPEED_LS_ON_FS);
    // Pull-up only as a device without both host pull-downs; HS term in HS with term set, out of low power and not non-driving
    assign FS_PULLUP_EN = settings_r[UFC_BIT_TERM] && speed != UFC_SPEED_HS
        && !host_pd && style != UFC_STYLE_RAW;
    assign HS_TERM_EN = settings_r[UFC_BIT_TERM] && !LOW_POWER
        && speed == UFC_SPEED_HS && style != UFC_STYLE_NODRIVE;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence reset_run_s;
        DIR [*2];
    endsequence

    sequence rxcmd_s;
        !DIR && RXCMD_REQ;
    endsequence

    write_base_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && REG_WR && REG_ADDR == UFC_ADDR_WRITE && !wake && state_r == UFC_ST_IDLE
        |=> settings_r == $past(REG_WDATA))
        else $error("Write did not replace register");
    set_or_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && REG_WR && REG_ADDR == UFC_ADDR_SET
        |=> (settings_r & $past(REG_WDATA)) == $past(REG_WDATA))
        else $error("Set did not set bits");
    clear_mask_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && REG_WR && REG_ADDR == UFC_ADDR_CLEAR && !wake && state_r == UFC_ST_IDLE
        |=> (settings_r & $past(REG_WDATA)) == 8'h00)
        else $error("Clear did not clear bits");
    read_window_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && !acc_hit |=> REG_RDATA == 8'h00)
        else $error("Read outside window not zero");
    wake_up_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && wake |=> settings_r[UFC_BIT_LOW_POWER_N])
        else $error("Wake did not restore powered bit");
    reset_dir_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && state_r == UFC_ST_IDLE && settings_r[UFC_BIT_CORE_RESET] |=> reset_run_s)
        else $error("DIR not raised for core reset");
    reset_end_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && DIR && cnt_r == '0 |=> rxcmd_s ##0 !settings_r[UFC_BIT_CORE_RESET])
        else $error("Core reset end sequence wrong");
    speed_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !LOW_POWER |-> $onehot({HS_XCVR_EN, FS_XCVR_EN, LS_XCVR_EN}))
        else $error("Transceiver select not one-hot");
    preamble_a: assert property (@(posedge CLK) disable iff (!RST_N)
        FS_PREAMBLE_EN |-> FS_XCVR_EN && !LS_XCVR_EN)
        else $error("Preamble without FS transceiver");
    low_power_a: assert property (@(posedge CLK) disable iff (!RST_N)
        LOW_POWER |-> !HS_XCVR_EN && !HS_TERM_EN)
        else $error("HS blocks powered in low power");
endmodule

// ===== rtl/ufc_pkg.sv
// Constants for the transceiver function-settings register block.
// Assumes a 6-bit register address space reached over the ULPI register port.
package ufc_pkg;
    localparam logic [5:0] UFC_ADDR_WRITE = 6'h04;
    localparam logic [5:0] UFC_ADDR_SET = 6'h05;
    localparam logic [5:0] UFC_ADDR_CLEAR = 6'h06;
    localparam logic [7:0] UFC_RESET_VAL = 8'h41;
    localparam int UFC_BIT_LOW_POWER_N = 6;
    localparam int UFC_BIT_CORE_RESET = 5;
    localparam int UFC_BIT_STYLE_HI = 4;
    localparam int UFC_BIT_STYLE_LO = 3;
    localparam int UFC_BIT_TERM = 2;
    localparam int UFC_BIT_SPEED_HI = 1;
    localparam int UFC_BIT_SPEED_LO = 0;
    localparam logic [1:0] UFC_STYLE_NORMAL = 2'h0;
    localparam logic [1:0] UFC_STYLE_NODRIVE = 2'h1;
    localparam logic [1:0] UFC_STYLE_RAW = 2'h2;
    localparam logic [1:0] UFC_STYLE_NOSYNC = 2'h3;
    localparam logic [1:0] UFC_SPEED_HS = 2'h0;
    localparam logic [1:0] UFC_SPEED_FS = 2'h1;
    localparam logic [1:0] UFC_SPEED_LS = 2'h2;
    localparam logic [1:0] UFC_SPEED_LS_ON_FS = 2'h3;
    localparam int UFC_CORE_RESET_CYCLES = 16;
    localparam int UFC_CNT_W = 8;
    typedef enum logic [2:0]
    {
        UFC_ST_IDLE = 3'b001,
        UFC_ST_CORE_RST = 3'b010,
        UFC_ST_RXCMD = 3'b100
    } ufc_state_t;
endpackage

// ===== rtl/ufc_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/10ps
module ufc_sync
    import ufc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Level
    input wire logic d,
    output logic q
);
    logic s1_r;
    logic s1_nxt;
    logic s2_r;
    logic s2_nxt;

    always_comb
    begin
        s1_nxt = ce ? d : s1_r;
        s2_nxt = ce ? s1_r : s2_r;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    assign q = s2_r;
endmodule

// ===== dv/ufc_link_model.sv
// Link-side model: register accesses and the wake request toward the block.
// Assumes the block samples its inputs on the rising edge of clk.
`timescale 1ns/10ps
module ufc_link_model
(
    // Clock and direction
    input wire logic clk,
    input wire logic dir,
    // Bus toward the block
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic stp
);
    initial
    begin
        reg_addr = 6'h04;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        stp = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One access; held off while the block owns the bus
    task automatic access(input logic [5:0] a, input logic [7:0] d, input logic wr);
        int n = 0;
        while (dir !== 1'b0 && n < 64)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Wake request, held for 200 ns (eight clock periods)
    task automatic wake();
        @(posedge clk);
        #1;
        stp = 1'b1;
        #200;
        stp = 1'b0;
    endtask
endmodule

// ===== dv/ufc_function_ctrl_test.sv
// Self-checking bench for the function-settings register block.
// Assumes the link model in ufc_link_model drives the register port and STP.
`timescale 1ns/10ps
module ufc_function_ctrl_test;
    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [1:0] pd; logic [7:0] r;
        logic [9:0] o;} ufc_row_t;
    localparam int NR = 7;
    localparam int CRC = 4;
    // Outputs: low power, hs, fs, ls, preamble, nodrive, raw, nosync, pullup, term
    ufc_row_t rows [NR] = '{
        '{6'h04, 8'h44, 2'b00, 8'h44, 10'h101},
        '{6'h05, 8'h09, 2'b00, 8'h4d, 10'h092},
        '{6'h05, 8'h02, 2'b11, 8'h4f, 10'h0b0},
        '{6'h06, 8'h0d, 2'b01, 8'h42, 10'h040},
        '{6'h04, 8'hd4, 2'b01, 8'hd4, 10'h109},
        '{6'h05, 8'h08, 2'b00, 8'hdc, 10'h105},
        '{6'h06, 8'hff, 2'b00, 8'h00, 10'h200}};
    logic CLK;
    logic RST_N;
    logic CE;
    logic pdp;
    logic pdn;
    logic [5:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic stp, dir, hit, rxcmd, lp, crst, hs, fs, ls, pre, nd, raw, nos, pu, term;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    ////////////////////////////////////////////////////////////////////////////
    ufc_function_ctrl #(.CORE_RESET_CYCLES(CRC)) i_ufc_function_ctrl (.CLK(CLK), .RST_N(RST_N),
        .CE(CE), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_HIT(hit), .STP(stp), .DIR(dir), .RXCMD_REQ(rxcmd), .POSITIVE_LINE_PULL_LOW(pdp),
        .NEGATIVE_LINE_PULL_LOW(pdn), .LOW_POWER(lp), .CORE_RESET(crst), .HS_XCVR_EN(hs),
        .FS_XCVR_EN(fs), .LS_XCVR_EN(ls), .FS_PREAMBLE_EN(pre), .TX_NON_DRIVING(nd),
        .TX_RAW_BITS(raw), .TX_NO_SYNC_EOP(nos), .FS_PULLUP_EN(pu), .HS_TERM_EN(term));
    ufc_link_model i_ufc_link_model (.clk(CLK), .dir(dir), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .stp(stp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        RST_N = 1'b0;
        CE = 1'b1;
        pdp = 1'b0;
        pdn = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        i_ufc_link_model.access(6'h04, 8'h00, 1'b0);
        chk({1'b0, hit, rdata}, 10'h141);
        chk({9'h000, dir}, 10'h000);
        for (int i = 0; i < NR; i++)
        begin
            {pdp, pdn} = rows[i].pd;
            i_ufc_link_model.access(rows[i].a, rows[i].d, 1'b1);
            chk({2'b00, rdata}, {2'b00, rows[i].r});
            chk({lp, hs, fs, ls, pre, nd, raw, nos, pu, term}, rows[i].o);
        end
        // Wake by STP without any register write
        i_ufc_link_model.wake();
        n = 0;
        while (lp !== 1'b0 && n < 16)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk({9'h000, lp}, 10'h000);
        i_ufc_link_model.access(6'h04, 8'h00, 1'b0);
        chk({2'b00, rdata}, 10'h040);
        // Core reset through a set access
        i_ufc_link_model.access(6'h05, 8'h20, 1'b1);
        n = 0;
        while (dir !== 1'b1 && n < 8)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        n = 0;
        while (dir === 1'b1 && n < 40)
        begin
            chk({9'h000, crst}, 10'h001);
            @(posedge CLK);
            #1;
            n++;
        end
        chk(n[9:0], 10'(CRC));
        chk({9'h000, rxcmd}, 10'h001);
        i_ufc_link_model.access(6'h04, 8'h00, 1'b0);
        chk({2'b00, rdata}, 10'h040);
        // Unmapped address leaves the register alone
        i_ufc_link_model.access(6'h07, 8'hff, 1'b1);
        chk({1'b0, hit, rdata}, 10'h000);
        i_ufc_link_model.access(6'h06, 8'h00, 1'b0);
        chk({2'b00, rdata}, 10'h040);
        // Nothing moves while CE is low
        CE = 1'b0;
        i_ufc_link_model.access(6'h04, 8'h95, 1'b1);
        chk({lp, 1'b0, rdata}, 10'h040);
        CE = 1'b1;
        i_ufc_link_model.access(6'h04, 8'h00, 1'b0);
        chk({2'b00, rdata}, 10'h040);
        // Mid-run reset brings back the default value
        i_ufc_link_model.access(6'h04, 8'h95, 1'b1);
        RST_N = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        chk({dir, lp, rdata}, 10'h000);
        i_ufc_link_model.access(6'h04, 8'h00, 1'b0);
        chk({2'b00, rdata}, 10'h041);
        tally_and_finish();
    end
endmodule
